// ### cfdcap_top.sv
// capability reporting, bit timing limits and receive path front end
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cfdcap_top
  import cfdcap_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic              write_strobe,
  input  wire logic              read_strobe,
  output logic      [DATA_W-1:0] read_data,
  input  wire logic              can_rx,
  output logic                   rx_sampled,
  output logic                   tq_nominal_tick,
  output logic                   tq_data_tick,
  input  wire logic              data_phase,
  output logic                   iso_format,
  output logic                   timing_valid,
  output logic                   ram_parity_error
);
  // build parameters checked at elaboration
  if (RX_DEPTH_WORDS < RX_DEPTH_MIN || RX_DEPTH_WORDS > RX_DEPTH_MAX) begin : g_bad_rx
    $error("receive depth out of range");
  end
  if (TXB_COUNT < TXB_MIN || TXB_COUNT > TXB_MAX) begin : g_bad_txb
    $error("transmit buffer count out of range");
  end

  logic [7:0] nom_presc, nom_seg1, nom_seg2;
  logic [7:0] dat_presc, dat_seg1, dat_seg2;
  logic       iso_mode;
  logic [RAM_AW-1:0] ram_addr;
  logic       nom_ok, dat_ok;
  logic [8:0] nom_len, dat_len;
  cfdcap_clr_t clr_state;
  logic [RAM_AW-1:0] clr_addr;
  logic [RX_LATENCY-1:0] rx_pipe;
  logic [7:0] nom_cnt, dat_cnt;
  logic [RAM_DW-1:0] ram_rd;
  logic       ram_we;
  logic [RAM_AW-1:0] ram_wa;
  logic [RAM_DW-1:0] ram_wd;
  logic       rd_ram_q;

  wire wr_hit = write_strobe && clr_state != CFDCAP_CLEAR;

  // bit length is sync segment plus both phase segments
  assign nom_len = 9'(nom_seg1) + 9'(nom_seg2) + 9'h001;
  assign dat_len = 9'(dat_seg1) + 9'(dat_seg2) + 9'h001;
  assign nom_ok  = nom_len >= 9'(NOM_BIT_MIN_TQ);
  assign dat_ok  = dat_len >= 9'(DATA_BIT_MIN_TQ);

  // nominal timing register; prescaler of zero is refused, keeping the old value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      nom_presc <= NOM_PRESC_RST;
      nom_seg1  <= NOM_SEG1_RST;
      nom_seg2  <= NOM_SEG2_RST;
    end else if (wr_hit && address == OFS_NOM_TIMING) begin
      if (write_data[PRESC_LSB +: 8] >= PRESC_MIN) begin
        nom_presc <= write_data[PRESC_LSB +: 8];
      end
      nom_seg1 <= write_data[SEG1_LSB +: 8];
      nom_seg2 <= write_data[SEG2_LSB +: 8];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dat_presc <= DATA_PRESC_RST;
      dat_seg1  <= DATA_SEG1_RST;
      dat_seg2  <= DATA_SEG2_RST;
    end else if (wr_hit && address == OFS_DATA_TIMING) begin
      if (write_data[PRESC_LSB +: 8] >= PRESC_MIN) begin
        dat_presc <= write_data[PRESC_LSB +: 8];
      end
      dat_seg1 <= write_data[SEG1_LSB +: 8];
      dat_seg2 <= write_data[SEG2_LSB +: 8];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      iso_mode <= CONFIG_ISO_RST;
    end else if (wr_hit && address == OFS_CONFIG) begin
      iso_mode <= write_data[BIT_ISO];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ram_addr <= '0;
    end else if (wr_hit && address == OFS_RAM_ADDR) begin
      ram_addr <= write_data[RAM_AW-1:0];
    end else if (wr_hit && address == OFS_RAM_DATA) begin
      ram_addr <= ram_addr + 1'b1;
    end
  end

  // quantum dividers: a prescaler of one gives a tick every clock, for the data divider only while data_phase is high
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      nom_cnt <= 8'h00;
    end else if (nom_cnt + 8'h01 >= nom_presc) begin
      nom_cnt <= 8'h00;
    end else begin
      nom_cnt <= nom_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dat_cnt <= 8'h00;
    end else if (!data_phase || dat_cnt + 8'h01 >= dat_presc) begin
      dat_cnt <= 8'h00;
    end else begin
      dat_cnt <= dat_cnt + 8'h01;
    end
  end

  assign tq_nominal_tick = nom_cnt + 8'h01 >= nom_presc;
  assign tq_data_tick    = data_phase && (dat_cnt + 8'h01 >= dat_presc);
  assign iso_format      = iso_mode;
  assign timing_valid    = nom_ok && dat_ok;

  // two-stage input path; idle bus level is recessive
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_pipe <= '1;
    end else begin
      rx_pipe <= {rx_pipe[RX_LATENCY-2:0], can_rx};
    end
  end
  assign rx_sampled = rx_pipe[RX_LATENCY-1];

  // buffer ram clearing after hardware reset, only when built in
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clr_state <= RESET_RAMS ? CFDCAP_CLEAR : CFDCAP_DONE;
      clr_addr  <= '0;
    end else begin
      case (clr_state)
        CFDCAP_CLEAR: begin
          if (clr_addr == RAM_AW'(RX_DEPTH_WORDS - 1)) begin
            clr_state <= CFDCAP_DONE;
          end
          clr_addr <= clr_addr + 1'b1;
        end
        CFDCAP_DONE: clr_state <= CFDCAP_DONE;
        default:     clr_state <= CFDCAP_DONE;
      endcase
    end
  end

  // even parity stored as the top bit of every word
  always_comb begin
    ram_we = 1'b0;
    ram_wa = ram_addr;
    ram_wd = {HAS_PARITY & (^write_data), write_data};
    if (clr_state == CFDCAP_CLEAR) begin
      ram_we = 1'b1;
      ram_wa = clr_addr;
      ram_wd = '0;
    end else if (write_strobe && address == OFS_RAM_DATA) begin
      ram_we = 1'b1;
    end
  end

  cfdcap_ram u_ram (
    .clock   (clock),
    .wr_en   (ram_we),
    .wr_addr (ram_wa),
    .wr_data (ram_wd),
    .rd_addr (ram_addr),
    .rd_data (ram_rd)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_ram_q <= 1'b0;
    end else begin
      rd_ram_q <= read_strobe && address == OFS_RAM_DATA;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ram_parity_error <= 1'b0;
    end else if (rd_ram_q) begin
      ram_parity_error <= HAS_PARITY && (^ram_rd) && clr_state == CFDCAP_DONE;
    end
  end

  // registered read; capability words are constants so writes cannot touch them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_data <= '0;
    end else if (read_strobe) begin
      case (address)
        OFS_STATUS: begin
          read_data <= '0;
          read_data[BIT_TRAFFIC]      <= HAS_TRAFFIC;
          read_data[BIT_TEST]         <= HAS_TEST;
          read_data[BIT_PARITY]       <= HAS_PARITY;
          read_data[BIT_TIMING_OK]    <= nom_ok && dat_ok;
          read_data[BIT_RAM_CLEARING] <= clr_state == CFDCAP_CLEAR;
        end
        OFS_FILTER:      read_data <= {28'h0000000, HAS_RANGE, HAS_FILT_3,
                                       HAS_FILT_2, HAS_FILT_1};
        OFS_RX_MEMORY_INFO: read_data <= DATA_W'(RX_DEPTH_WORDS);
        OFS_TXB_INFO:    read_data <= DATA_W'(TXB_COUNT);
        OFS_TS_INFO:     read_data <= DATA_W'(TS_BITS - 1);
        OFS_NOM_TIMING:  read_data <= {8'h00, nom_seg2, nom_seg1, nom_presc};
        OFS_DATA_TIMING: read_data <= {8'h00, dat_seg2, dat_seg1, dat_presc};
        OFS_CONFIG:      read_data <= {31'h00000000, iso_mode};
        OFS_RAM_ADDR:    read_data <= DATA_W'(ram_addr);
        default:         read_data <= '0;
      endcase
    end else begin
      read_data <= '0;
    end
  end

  // ram words are not mapped onto read_data: a read of the data offset only
  // refreshes the parity flag, since the ram output lands one cycle too late

  // assertions
  rx_latency_a : assert property (@(posedge clock) disable iff (!reset_n)
    ##2 rx_sampled == $past(can_rx, 2))
    else $error("receive latency not two clocks");
  nom_presc_a : assert property (@(posedge clock) disable iff (!reset_n)
    nom_presc >= PRESC_MIN)
    else $error("nominal prescaler left range");
  data_presc_a : assert property (@(posedge clock) disable iff (!reset_n)
    dat_presc >= PRESC_MIN)
    else $error("data prescaler left range");
  nom_len_a : assert property (@(posedge clock) disable iff (!reset_n)
    timing_valid |-> nom_len >= 9'h008)
    else $error("nominal bit too short flagged valid");
  data_len_a : assert property (@(posedge clock) disable iff (!reset_n)
    timing_valid |-> dat_len >= 9'h005)
    else $error("data bit too short flagged valid");
  tq_one_a : assert property (@(posedge clock) disable iff (!reset_n)
    nom_presc == 8'h01 |-> tq_nominal_tick)
    else $error("quantum of one clock not ticking");
  info_read_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_RX_MEMORY_INFO |=> read_data == 32'(RX_DEPTH_WORDS))
    else $error("receive depth misreported");
  txb_read_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_TXB_INFO |=> read_data == 32'(TXB_COUNT))
    else $error("transmit buffer count misreported");
  status_read_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_STATUS |=> read_data[2:0] == {HAS_PARITY, HAS_TEST,
                                                                HAS_TRAFFIC})
    else $error("status presence flags wrong");
  ts_read_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_TS_INFO |=> read_data == 32'(TS_BITS - 1))
    else $error("time base width misreported");
  iso_cfg_a : assert property (@(posedge clock) disable iff (!reset_n)
    wr_hit && address == OFS_CONFIG |=> iso_format == $past(write_data[0]))
    else $error("frame format select lost");

  // register side, buffer ram and data quantum checks
  filter_read_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_FILTER |=>
      read_data == {28'h0000000, HAS_RANGE, HAS_FILT_3, HAS_FILT_2, HAS_FILT_1})
    else $error("filter presence flags wrong");
  test_flag_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_STATUS |=> read_data[BIT_TEST] == HAS_TEST)
    else $error("test region flag wrong");
  parity_flag_a : assert property (@(posedge clock) disable iff (!reset_n)
    read_strobe && address == OFS_STATUS |=> read_data[BIT_PARITY] == HAS_PARITY)
    else $error("parity flag wrong");
  parity_word_a : assert property (@(posedge clock) disable iff (!reset_n)
    HAS_PARITY && ram_we && clr_state != CFDCAP_CLEAR |-> (^ram_wd) == 1'b0)
    else $error("stored word parity wrong");
  ram_clear_a : assert property (@(posedge clock) disable iff (!reset_n)
    clr_state == CFDCAP_CLEAR |-> ram_we && ram_wd == '0)
    else $error("buffer ram not cleared");
  nom_keep_a : assert property (@(posedge clock) disable iff (!reset_n)
    wr_hit && address == OFS_NOM_TIMING && write_data[7:0] == 8'h00 |=> $stable(nom_presc))
    else $error("nominal prescaler took zero");
  data_keep_a : assert property (@(posedge clock) disable iff (!reset_n)
    wr_hit && address == OFS_DATA_TIMING && write_data[7:0] == 8'h00 |=> $stable(dat_presc))
    else $error("data prescaler took zero");
  read_idle_a : assert property (@(posedge clock) disable iff (!reset_n)
    !read_strobe |=> read_data == '0)
    else $error("read data outside answer cycle");
  data_idle_a : assert property (@(posedge clock) disable iff (!reset_n)
    !data_phase |-> !tq_data_tick)
    else $error("data quantum outside data phase");

  nom_write_c : cover property (@(posedge clock) disable iff (!reset_n)
    write_strobe && address == OFS_NOM_TIMING);
  zero_presc_c : cover property (@(posedge clock) disable iff (!reset_n)
    write_strobe && address == OFS_DATA_TIMING && write_data[7:0] == 8'h00);
  clear_done_c : cover property (@(posedge clock) disable iff (!reset_n)
    clr_state == CFDCAP_CLEAR ##1 clr_state == CFDCAP_DONE);
  bad_timing_c : cover property (@(posedge clock) disable iff (!reset_n) !timing_valid);
  iso_write_c : cover property (@(posedge clock) disable iff (!reset_n)
    wr_hit && address == OFS_CONFIG && !write_data[0]);
endmodule
`default_nettype wire

// ### cfdcap_pkg.sv
// package of constants for the capability and parameter block
package cfdcap_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS      = 8'h00;
  localparam logic [7:0] OFS_FILTER      = 8'h04;
  localparam logic [7:0] OFS_RX_MEMORY_INFO = 8'h08;
  localparam logic [7:0] OFS_TXB_INFO    = 8'h0C;
  localparam logic [7:0] OFS_TS_INFO     = 8'h10;
  localparam logic [7:0] OFS_NOM_TIMING  = 8'h14;
  localparam logic [7:0] OFS_DATA_TIMING = 8'h18;
  localparam logic [7:0] OFS_CONFIG      = 8'h1C;
  localparam logic [7:0] OFS_RAM_ADDR    = 8'h20;
  localparam logic [7:0] OFS_RAM_DATA    = 8'h24;
  // status field positions
  localparam int BIT_TRAFFIC = 0;
  localparam int BIT_TEST    = 1;
  localparam int BIT_PARITY  = 2;
  localparam int BIT_TIMING_OK = 3;
  localparam int BIT_RAM_CLEARING = 4;
  // timing register fields: prescaler [7:0], seg1 [15:8], seg2 [23:16]
  localparam int PRESC_LSB = 0;
  localparam int SEG1_LSB  = 8;
  localparam int SEG2_LSB  = 16;
  localparam logic [7:0] PRESC_MIN = 8'h01;
  localparam logic [7:0] NOM_BIT_MIN_TQ  = 8'h08;
  localparam logic [7:0] DATA_BIT_MIN_TQ = 8'h05;
  localparam logic [7:0] NOM_PRESC_RST  = 8'h01;
  localparam logic [7:0] DATA_PRESC_RST = 8'h01;
  localparam logic [7:0] NOM_SEG1_RST   = 8'h05;
  localparam logic [7:0] NOM_SEG2_RST   = 8'h02;
  localparam logic [7:0] DATA_SEG1_RST  = 8'h02;
  localparam logic [7:0] DATA_SEG2_RST  = 8'h02;
  localparam int BIT_ISO = 0;
  localparam logic CONFIG_ISO_RST = 1'b1;
  // fixed receive input latency in clocks
  localparam int RX_LATENCY = 2;
  // build-time capability defaults
  localparam int  RX_DEPTH_WORDS = 32;
  localparam int  RX_DEPTH_MIN   = 32;
  localparam int  RX_DEPTH_MAX   = 4096;
  localparam int  TXB_COUNT      = 4;
  localparam int  TXB_MIN        = 2;
  localparam int  TXB_MAX        = 8;
  localparam bit  HAS_FILT_1 = 1'b1;
  localparam bit  HAS_FILT_2 = 1'b1;
  localparam bit  HAS_FILT_3 = 1'b0;
  localparam bit  HAS_RANGE  = 1'b1;
  localparam bit  HAS_TRAFFIC = 1'b1;
  localparam bit  HAS_TEST    = 1'b1;
  localparam bit  HAS_PARITY  = 1'b1;
  localparam bit  RESET_RAMS  = 1'b1;
  localparam int  TS_BITS     = 64;
  localparam int  RAM_DW = DATA_W + 1;
  localparam int  RAM_AW = 12;
  typedef enum logic [1:0] {
    CFDCAP_IDLE  = 2'b00,
    CFDCAP_CLEAR = 2'b01,
    CFDCAP_DONE  = 2'b11
  } cfdcap_clr_t;
endpackage

// ### cfdcap_ram.sv
// receive buffer word memory with registered read data and parity
`timescale 1ns/1ps
`default_nettype none
module cfdcap_ram
  import cfdcap_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [RAM_AW-1:0] wr_addr,
  input  wire logic [RAM_DW-1:0] wr_data,
  input  wire logic [RAM_AW-1:0] rd_addr,
  output logic      [RAM_DW-1:0] rd_data
);
  // no reset on the array: clearing is done word by word by the owner
  logic [RAM_DW-1:0] mem [RX_DEPTH_WORDS];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr[$clog2(RX_DEPTH_WORDS)-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr[$clog2(RX_DEPTH_WORDS)-1:0]];
  end
endmodule
`default_nettype wire

// ### cfdcap_bus_model.sv
// bus transceiver model that drives the receive pin
`timescale 1ns/1ps
`default_nettype none
module cfdcap_bus_model (
  input  wire logic clock,
  input  wire logic active,
  output logic      can_rx
);
  int seed = 52999;
  initial can_rx = 1'b1;
  // outside frames the termination pulls the bus recessive, so idle reads 1
  always @(posedge clock) can_rx <= active ? 1'($random(seed)) : 1'b1;
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the capability block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cfdcap_pkg::*;
  logic              clock, reset_n, write_strobe, read_strobe, data_phase, bus_on;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] write_data, read_data;
  logic              can_rx, rx_sampled, tq_nominal_tick, tq_data_tick;
  logic              iso_format, timing_valid, ram_parity_error;
  logic [31:0]       expq[$];
  logic              pend = 1'b0;
  logic [1:0]        hist = 2'b11;
  logic [7:0]        p;
  int                err_count = 0, checked = 0, seed = 52999, live = 0;
  cfdcap_top dut_u (.clock(clock), .reset_n(reset_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .can_rx(can_rx), .rx_sampled(rx_sampled),
    .tq_nominal_tick(tq_nominal_tick), .tq_data_tick(tq_data_tick),
    .data_phase(data_phase), .iso_format(iso_format), .timing_valid(timing_valid),
    .ram_parity_error(ram_parity_error));
  cfdcap_bus_model bus_u (.clock(clock), .active(bus_on), .can_rx(can_rx));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one idle cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(posedge clock);
  endtask
  task automatic ticks(input bit dsel, input int n, input int exp);
    int c;
    c = 0;
    repeat (2) @(posedge clock);
    repeat (n) begin
      @(posedge clock);
      if ((dsel ? tq_data_tick : tq_nominal_tick) === 1'b1) c++;
    end
    cmp(32'(c), 32'(exp));
  endtask
  // values sampled before the edge's own updates land
  always @(posedge clock) begin
    pend <= read_strobe;
    hist <= {hist[0], can_rx};
    live <= reset_n ? live + 1 : 0;
    if (pend) cmp(read_data, expq.pop_front());
    else if (live > 0) cmp(read_data, 32'h0);
    if (live > 3) cmp1(rx_sampled, hist[1]);
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    conclude();
  end
  initial begin
    reset_n = 1'b0;
    address = '0;
    write_data = '0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    data_phase = 1'b0;
    bus_on = 1'b0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    bus_on <= 1'b1;
    repeat (2) @(posedge clock);
    rd(OFS_STATUS, {27'h0, 2'b11, HAS_PARITY, HAS_TEST, HAS_TRAFFIC});
    wr(OFS_NOM_TIMING, 32'h00020303);
    repeat (RX_DEPTH_WORDS) @(posedge clock);
    $display("test reset done");
    rd(OFS_NOM_TIMING, 32'h00020501);
    rd(OFS_DATA_TIMING, 32'h00020201);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_STATUS + 8'(4 * i), 32'($random(seed)));
    end
    rd(OFS_STATUS, {28'h0, 1'b1, HAS_PARITY, HAS_TEST, HAS_TRAFFIC});
    rd(OFS_FILTER, {28'h0, HAS_RANGE, HAS_FILT_3, HAS_FILT_2, HAS_FILT_1});
    rd(OFS_RX_MEMORY_INFO, 32'(RX_DEPTH_WORDS));
    rd(OFS_TXB_INFO, 32'(TXB_COUNT));
    rd(OFS_TS_INFO, 32'(TS_BITS - 1));
    rd(8'h30, 32'h0);
    $display("test capability done");
    bus_on <= 1'b0;
    wr(OFS_NOM_TIMING, 32'h00020401);
    cmp1(timing_valid, 1'b0);
    wr(OFS_NOM_TIMING, 32'h00020501);
    cmp1(timing_valid, 1'b1);
    wr(OFS_DATA_TIMING, 32'h00020101);
    cmp1(timing_valid, 1'b0);
    wr(OFS_DATA_TIMING, 32'h00020201);
    cmp1(timing_valid, 1'b1);
    wr(OFS_NOM_TIMING, 32'h00020600);
    rd(OFS_NOM_TIMING, 32'h00020601);
    wr(OFS_DATA_TIMING, 32'h00030200);
    rd(OFS_DATA_TIMING, 32'h00030201);
    repeat (4) begin
      p = 8'($random(seed));
      if (p == 8'h00) p = 8'hFF;
      wr(OFS_NOM_TIMING, {16'h0002, 8'h05, p});
      rd(OFS_NOM_TIMING, {16'h0002, 8'h05, p});
      wr(OFS_DATA_TIMING, {16'h0002, 8'h02, p});
      rd(OFS_DATA_TIMING, {16'h0002, 8'h02, p});
    end
    $display("test timing done");
    bus_on <= 1'b1;
    wr(OFS_NOM_TIMING, 32'h00020501);
    ticks(1'b0, 10, 10);
    wr(OFS_NOM_TIMING, 32'h00020503);
    ticks(1'b0, 30, 10);
    wr(OFS_DATA_TIMING, 32'h00020201);
    data_phase <= 1'b1;
    ticks(1'b1, 10, 10);
    wr(OFS_DATA_TIMING, 32'h00020202);
    ticks(1'b1, 20, 10);
    data_phase <= 1'b0;
    ticks(1'b1, 20, 0);
    $display("test quanta done");
    rd(OFS_CONFIG, 32'h1);
    cmp1(iso_format, 1'b1);
    wr(OFS_CONFIG, 32'h0);
    cmp1(iso_format, 1'b0);
    rd(OFS_CONFIG, 32'h0);
    wr(OFS_CONFIG, 32'h1);
    cmp1(iso_format, 1'b1);
    wr(OFS_RAM_ADDR, 32'h0);
    repeat (4) wr(OFS_RAM_DATA, 32'($random(seed)));
    for (int i = 0; i < 4; i++) begin
      wr(OFS_RAM_ADDR, 32'(i));
      rd(OFS_RAM_DATA, 32'h0);
      // the flag is registered at the edge that ends the read task
      @(posedge clock);
      cmp1(ram_parity_error, 1'b0);
    end
    $display("test config and memory done");
    repeat (4) @(posedge clock);
    conclude();
  end
endmodule
`default_nettype wire
